// ---- src/s2pr_receiver.sv ----
// Summary of operation
// - two lane-select pins choose one, two or three serial data lanes.
// - low receiver enable puts the receiver into shutdown.
// - forwarded clock going quiet drops the receiver into standby by itself.
// - receiver locks to forwarded clock and runs one bit slot per lane bit.
// - serial lane bits are shifted into a frame shift register.
// - deserialized word drives the bus; pixel clock is the bit clock divided.
// - without forwarded clock: pixel clock, enable and parity error low; pixel bus and syncs high.
// - swap pin reverses the 24 pixel bits; syncs and enable stay put.
// - select 00 one lane/30 bits, 01 two/15, 10 three/10, 11 reserved.
// - odd parity over 27 bits; error pulses half pixel clock, word held.
// - in shutdown lane inputs are ignored and the idle pattern is shown.
// - idle pattern shown while acquiring lock; data only after lock.
`timescale 1ns/1ps
`default_nettype none
module s2pr_receiver
    import s2pr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receiver_enable_pin,
    input wire logic lane_select_low,
    input wire logic lane_select_high,
    input wire logic bus_swap,
    input wire logic forwarded_clock,
    input wire logic serial_lane_0,
    input wire logic serial_lane_1,
    input wire logic serial_lane_2,
    output logic [PIXEL_BITS-1:0] pixel_out,
    output logic vertical_sync,
    output logic horizontal_sync,
    output logic display_enable,
    output logic pixel_clk_out,
    output logic parity_error_out,
    output logic irq
);
    function automatic logic [4:0] lane_period(input logic [1:0] sel);
        case (sel)
            SINGLE_LANE_MODE: lane_period = BITS_SINGLE;
            DUAL_LANE_MODE: lane_period = BITS_DUAL;
            TRIPLE_LANE_MODE: lane_period = BITS_TRIPLE;
            default: lane_period = BITS_SINGLE;
        endcase
    endfunction

    function automatic logic [PIXEL_BITS-1:0] order_pixels(input logic [PIXEL_BITS-1:0] p,
                                                         input logic swap);
        order_pixels = p;
        if (swap) begin
            for (int i = 0; i < PIXEL_BITS; i++) begin
                order_pixels[i] = p[PIXEL_BITS-1-i];
            end
        end
    endfunction

    s2pr_state_e state, next_state;
    logic [1:0] lane_sel;
    logic [4:0] bpl;
    logic [6:0] half;
    logic fwd_clk_q;
    logic rise;
    logic [6:0] gap_cnt, next_gap;
    logic next_present;
    logic period_ok;
    logic [3:0] lock_cnt, next_lock;
    logic ctrl_en;
    logic sys_en;
    logic [FRAME_BITS-1:0] frame_sr;
    logic word_done;
    logic parity_good;
    logic next_high;
    logic [PIXEL_BITS-1:0] rx_pixel;
    logic [INT_W-1:0] int_status, int_enable, int_events, int_clear;
    logic [15:0] perr_count;
    logic wr_en;
    logic setup;

    assign lane_sel = {lane_select_high, lane_select_low};
    assign bpl = lane_period(lane_sel);
    assign half = {3'h0, bpl[4:1]};
    assign sys_en = receiver_enable_pin & ctrl_en;
    assign rise = forwarded_clock & ~fwd_clk_q;

    // edge spacing tells us the clock is present and at the lane rate
    assign next_gap = rise ? 7'h0 : (gap_cnt == CLK_LOSS_CYCLES ? gap_cnt : gap_cnt + 7'h1);
    assign next_present = next_gap < CLK_LOSS_CYCLES;
    assign period_ok = rise && (gap_cnt == {2'h0, bpl - 5'h1});

    always_comb begin
        next_lock = lock_cnt;
        if (!sys_en || !next_present || lane_sel == LANES_RESERVED) begin
            next_lock = 4'h0;
        end else if (rise) begin
            // one bad period restarts acquisition, so a mode change relocks
            if (!period_ok) begin
                next_lock = 4'h0;
            end else if (lock_cnt != LOCK_PERIODS) begin
                next_lock = lock_cnt + 4'h1;
            end
        end
    end

    always_comb begin
        if (!sys_en) begin
            next_state = S2PR_SHUTDOWN;
        end else if (lane_sel == LANES_RESERVED || !next_present) begin
            next_state = S2PR_STANDBY;
        end else if (next_lock == LOCK_PERIODS) begin
            next_state = S2PR_RECEIVE;
        end else begin
            next_state = S2PR_ACQUIRE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S2PR_STANDBY;
            lock_cnt <= 4'h0;
            gap_cnt <= CLK_LOSS_CYCLES;
            // released clock idles high; a low value here would fake a rise
            fwd_clk_q <= 1'b1;
        end else begin
            state <= next_state;
            lock_cnt <= next_lock;
            gap_cnt <= next_gap;
            fwd_clk_q <= forwarded_clock;
        end
    end

    // lanes are only looked at while the recovery is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sr <= '0;
        end else if (state == S2PR_ACQUIRE || state == S2PR_RECEIVE) begin
            case (lane_sel)
                SINGLE_LANE_MODE: frame_sr <= {frame_sr[28:0], serial_lane_0};
                DUAL_LANE_MODE: frame_sr <= {frame_sr[27:0], serial_lane_0, serial_lane_1};
                TRIPLE_LANE_MODE: frame_sr <= {frame_sr[26:0], serial_lane_0, serial_lane_1,
                                               serial_lane_2};
                default: frame_sr <= frame_sr;
            endcase
        end
    end

    // a frame is the bits sampled from one clock rise up to the next
    assign word_done = rise && state == S2PR_RECEIVE;
    assign parity_good = ^frame_sr[PARITY_POS:0];
    // pulse starts only at a frame rise, so no stub pulse right after lock
    assign next_high = rise || (pixel_clk_out && half > gap_cnt + 7'h1);
    assign rx_pixel = order_pixels(frame_sr[PIX_LSB+PIXEL_BITS-1:PIX_LSB], bus_swap);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_out <= IDLE_PIXEL;
            vertical_sync <= 1'b1;
            horizontal_sync <= 1'b1;
            display_enable <= 1'b0;
        end else if (state != S2PR_RECEIVE) begin
            pixel_out <= IDLE_PIXEL;
            vertical_sync <= 1'b1;
            horizontal_sync <= 1'b1;
            display_enable <= 1'b0;
        end else if (word_done && parity_good) begin
            pixel_out <= rx_pixel;
            vertical_sync <= frame_sr[VS_POS];
            horizontal_sync <= frame_sr[HS_POS];
            display_enable <= frame_sr[DE_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_clk_out <= 1'b0;
            parity_error_out <= 1'b0;
        end else begin
            pixel_clk_out <= state == S2PR_RECEIVE && next_high;
            // error pulse shares the high half of the pixel clock
            parity_error_out <= state == S2PR_RECEIVE && next_high &&
                                (rise ? !parity_good : parity_error_out);
        end
    end

    // register slave: zero wait states, read data captured in setup
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign int_clear = (wr_en && paddr == ADDR_INT_CLEAR) ? pwdata[INT_W-1:0] : '0;
    assign int_events = {state == S2PR_RECEIVE && next_state != S2PR_RECEIVE,
                         state != S2PR_RECEIVE && next_state == S2PR_RECEIVE,
                         word_done && !parity_good};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en <= CTRL_EN_RESET;
            int_enable <= '0;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_en <= pwdata[CTRL_EN_BIT];
        end else if (wr_en && paddr == ADDR_INT_ENABLE) begin
            int_enable <= pwdata[INT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
            perr_count <= 16'h0;
        end else begin
            // a new event wins over a clear in the same cycle
            int_status <= (int_status & ~int_clear) | int_events;
            if (int_events[INT_PERR]) begin
                perr_count <= perr_count + 16'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= 1'b0;
            case (paddr)
                ADDR_CTRL: prdata <= {31'h0, ctrl_en};
                ADDR_STATUS: prdata <= {27'h0, bus_swap, lane_sel, state};
                ADDR_INT_STATUS: prdata <= {29'h0, int_status};
                ADDR_INT_ENABLE: prdata <= {29'h0, int_enable};
                ADDR_INT_CLEAR: prdata <= 32'h0;
                ADDR_PERR_COUNT: prdata <= {16'h0, perr_count};
                default: begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    assign irq = |(int_status & int_enable);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence good_word_s;
        word_done && parity_good;
    endsequence
    sequence word_shown_s;
        pixel_out == $past(rx_pixel) && pixel_clk_out;
    endsequence

    idle_pattern_a: assert property (state != S2PR_RECEIVE |=> pixel_out == IDLE_PIXEL &&
        vertical_sync && horizontal_sync && !display_enable && !pixel_clk_out)
        else $error("idle pattern missing");
    shutdown_entry_a: assert property (!receiver_enable_pin |=> state == S2PR_SHUTDOWN)
        else $error("no shutdown on low enable");
    standby_entry_a: assert property (sys_en && gap_cnt == CLK_LOSS_CYCLES &&
        !rise |=> state == S2PR_STANDBY) else $error("no standby on lost clock");
    lock_gate_a: assert property (state == S2PR_RECEIVE |-> lock_cnt == LOCK_PERIODS)
        else $error("receive before lock");
    lane_rate_a: assert property (state == S2PR_RECEIVE && rise |->
        gap_cnt == {2'h0, bpl - 5'h1}) else $error("clock period off lane rate");
    reserved_mode_a: assert property (sys_en && lane_sel == LANES_RESERVED |=>
        state == S2PR_STANDBY) else $error("reserved lane select not idle");
    word_load_a: assert property (good_word_s |=> word_shown_s)
        else $error("word not presented with pixel clock");
    parity_hold_a: assert property (word_done && !parity_good |=>
        parity_error_out && $stable(pixel_out)) else $error("parity error not handled");
    shift_in_a: assert property (state == S2PR_RECEIVE && lane_sel == SINGLE_LANE_MODE |=>
        frame_sr[0] == $past(serial_lane_0)) else $error("lane bit not shifted");
    coherent_bus_a: assert property (!$stable(pixel_out) && state == S2PR_RECEIVE |->
        $rose(pixel_clk_out)) else $error("bus changed off pixel clock edge");
    pclk_start_a: assert property ($rose(pixel_clk_out) |-> $past(word_done))
        else $error("pixel clock started without a word");
    perr_inside_a: assert property (parity_error_out |-> pixel_clk_out)
        else $error("parity pulse outside pixel clock high");
    lanes_ignored_a: assert property (state == S2PR_SHUTDOWN |=> $stable(frame_sr))
        else $error("lanes shifted in shutdown");
    swap_order_a: assert property (good_word_s && bus_swap |=>
        pixel_out[0] == $past(frame_sr[PIX_LSB+PIXEL_BITS-1]))
        else $error("swapped order wrong");
    plain_order_a: assert property (good_word_s && !bus_swap |=>
        pixel_out[0] == $past(frame_sr[PIX_LSB])) else $error("plain order wrong");
    sync_place_a: assert property (good_word_s |=>
        display_enable == $past(frame_sr[DE_POS]) && vertical_sync == $past(frame_sr[VS_POS]) &&
        horizontal_sync == $past(frame_sr[HS_POS])) else $error("sync or enable moved");

    // helper for the width check; a count keeps the property short
    logic [6:0] pck_high;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pck_high <= 7'h0;
        end else begin
            pck_high <= pixel_clk_out ? pck_high + 7'h1 : 7'h0;
        end
    end
    pclk_width_a: assert property (pixel_clk_out |-> pck_high < half)
        else $error("pixel clock high too long");
endmodule // s2pr_receiver
`default_nettype wire

// ---- src/s2pr_pkg.sv ----
package s2pr_pkg;
    localparam int FRAME_BITS = 30;
    localparam int PARITY_POS = 27;
    localparam int PIXEL_BITS = 24;
    localparam int PIX_LSB = 3;
    localparam int VS_POS = 2;
    localparam int HS_POS = 1;
    localparam int DE_POS = 0;

    localparam logic [1:0] SINGLE_LANE_MODE = 2'h0;
    localparam logic [1:0] DUAL_LANE_MODE = 2'h1;
    localparam logic [1:0] TRIPLE_LANE_MODE = 2'h2;
    localparam logic [1:0] LANES_RESERVED = 2'h3;

    localparam logic [4:0] BITS_SINGLE = 5'h1e;
    localparam logic [4:0] BITS_DUAL = 5'h0f;
    localparam logic [4:0] BITS_TRIPLE = 5'h0a;

    localparam logic [6:0] CLK_LOSS_CYCLES = 7'h40;
    localparam logic [3:0] LOCK_PERIODS = 4'h8;
    localparam logic [23:0] IDLE_PIXEL = 24'hffffff;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_PERR_COUNT = 8'h14;

    localparam int CTRL_EN_BIT = 0;
    localparam int INT_W = 3;
    localparam int INT_PERR = 0;
    localparam int INT_LOCK = 1;
    localparam int INT_LOST = 2;
    localparam logic CTRL_EN_RESET = 1'b1;

    typedef enum logic [1:0] {
        S2PR_STANDBY = 2'b00,
        S2PR_ACQUIRE = 2'b01,
        S2PR_RECEIVE = 2'b11,
        S2PR_SHUTDOWN = 2'b10
    } s2pr_state_e;
endpackage

// ---- testbench/s2pr_tx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module s2pr_tx_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic [1:0] lanes,
    input wire logic [29:0] word,
    output logic fclk,
    output logic [2:0] lane,
    output logic due
);
    int cnt = 0;
    int n;
    int bpl;
    logic [29:0] sh = '0;
    logic [29:0] cur;
    assign n = (lanes == 2'h0) ? 1 : (lanes == 2'h1) ? 2 : 3;
    assign bpl = 30 / n;
    assign cur = (cnt == 0) ? word : sh;
    initial begin
        fclk = 1'b1;
        lane = 3'h0;
        due = 1'b0;
    end
    always @(posedge pclk) begin
        if (!run) begin
            // released clock floats high: no rises; idle lanes keep moving
            fclk <= 1'b1;
            lane <= ~lane;
            cnt <= 0;
            due <= 1'b0;
        end else begin
            sh <= cur;
            fclk <= (cnt < bpl / 2);
            // one cycle of warning so the next word is ready at frame start
            due <= (cnt == bpl - 2);
            cnt <= (cnt == bpl - 1) ? 0 : cnt + 1;
            for (int i = 0; i < 3; i++) begin
                lane[i] <= (i < n) ? cur[29 - n * cnt - i] : ~lane[i];
            end
        end
    end
endmodule // s2pr_tx_model
`default_nettype wire

// ---- testbench/test_serial_to_parallel_pixel_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serial_to_parallel_pixel_receiver;
    import s2pr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, fclk, due, perr, pck, vs, hs, de, irq;
    logic ren = 1, ls_lo = 0, ls_hi = 0, swap = 0, run = 0, pck_q = 0;
    logic [2:0] lane;
    logic [23:0] pix;
    logic [29:0] word = '0;
    logic [27:0] exq [$];
    int err_count = 0, checked = 0, cyc = 0, hi = 0, bpl = 30;
    initial forever #20 pclk = ~pclk;
    s2pr_receiver i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .receiver_enable_pin(ren), .lane_select_low(ls_lo),
        .lane_select_high(ls_hi), .bus_swap(swap), .forwarded_clock(fclk),
        .serial_lane_0(lane[0]), .serial_lane_1(lane[1]), .serial_lane_2(lane[2]),
        .pixel_out(pix), .vertical_sync(vs), .horizontal_sync(hs), .display_enable(de),
        .pixel_clk_out(pck), .parity_error_out(perr), .irq);
    s2pr_tx_model i_tx (.pclk, .run, .lanes({ls_hi, ls_lo}), .word, .fclk, .lane, .due);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic chk_idle(input logic [1:0] st);
        chk({pix, vs, hs, de, pck}, {IDLE_PIXEL, 4'hc});
        apb(0, ADDR_STATUS, 0);
        chk(rd[4:0], {swap, ls_hi, ls_lo, st});
    endtask
    function automatic logic [27:0] ex(input logic [29:0] w);
        logic [23:0] p;
        for (int i = 0; i < 24; i++) p[i] = swap ? w[26 - i] : w[3 + i];
        return {1'b0, p, w[2:0]};
    endfunction
    function automatic logic [29:0] mk(input logic bad);
        logic [26:0] r;
        r = 27'($urandom);
        return {2'h0, ~^r ^ bad, r};
    endfunction
    // a word reaches the bus at the rise that ends its frame
    task automatic stream(input logic [1:0] m, input int nfr);
        logic [27:0] e;
        logic [27:0] last;
        {ls_hi, ls_lo} <= m;
        swap <= (m == 2'h1);
        bpl = 30 / (m + 1);
        apb(1, ADDR_INT_CLEAR, 7);
        apb(1, ADDR_INT_ENABLE, 2);
        word <= mk(0);
        run <= 1;
        @(posedge pclk);
        last = ex(word);
        while (irq !== 1'b1) @(posedge pclk);
        apb(1, ADDR_INT_CLEAR, 2);
        for (int k = 0; k < nfr; k++) begin
            @(posedge pclk iff due);
            e = ex(word);
            if (^word[27:0]) last = e;
            else e = {1'b1, last[26:0]};
            exq.push_back(e);
            word <= mk(k == 2);
            if (k == nfr - 1 && nfr > 2) run <= 0;
        end
    endtask
    always @(negedge pclk) begin
        if (pck === 1'b1 && pck_q === 1'b0) begin
            if (exq.size() == 0) chk(1, 0);
            else chk({perr, pix, vs, hs, de}, exq.pop_front());
        end
        if (perr === 1'b1) chk(pck, 1);
        if (pck === 1'b1) hi++;
        else if (pck_q === 1'b1) begin
            chk(hi, bpl / 2);
            hi = 0;
        end
        pck_q = pck;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            print_verdict;
        end
    end
    initial begin
        void'($urandom(66));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk_idle(2'h0);
        apb(0, 8'h20, 0);
        chk(er, 1);
        chk(rd, 0);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 1);
        apb(1, ADDR_CTRL, 0);
        chk_idle(2'h2);
        apb(1, ADDR_CTRL, 1);
        for (int m = 0; m < 3; m++) begin
            stream(m, 6);
            repeat (90) @(posedge pclk);
            chk(exq.size(), 0);
            chk_idle(2'h0);
            apb(0, ADDR_INT_STATUS, 0);
            chk(rd[2:0], 3'h5);
            chk(irq, 0);
            apb(1, ADDR_INT_ENABLE, 1);
            chk(irq, 1);
            apb(1, ADDR_INT_CLEAR, 7);
            chk(irq, 0);
            apb(0, ADDR_PERR_COUNT, 0);
            chk(rd[15:0], m + 1);
        end
        // shutdown mid-frame while the pixel clock is low
        stream(2, 2);
        repeat (8) @(posedge pclk);
        ren <= 0;
        repeat (3) @(posedge pclk);
        chk_idle(2'h2);
        {ls_hi, ls_lo} <= 2'h3;
        ren <= 1;
        repeat (100) @(posedge pclk);
        chk_idle(2'h0);
        print_verdict;
    end
endmodule // test_serial_to_parallel_pixel_receiver
`default_nettype wire
